// ---- src/oafd_pkg.sv ----
// package of field codes, register indices and identity constants for the operand decoder
package oafd_pkg;
   // ----------------------------------------
   // general register indices
   // ----------------------------------------
   localparam logic [2:0] GPR_ACC = 3'h0;
   localparam logic [2:0] GPR_CNT = 3'h1;
   localparam logic [2:0] GPR_DAT = 3'h2;
   localparam logic [2:0] GPR_BAS = 3'h3;
   localparam logic [2:0] GPR_STK = 3'h4;
   localparam logic [2:0] GPR_FRM = 3'h5;
   localparam logic [2:0] GPR_SRC = 3'h6;
   localparam logic [2:0] GPR_DST = 3'h7;
   // ----------------------------------------
   // operand size encodings on reg_size_out
   // ----------------------------------------
   localparam logic [1:0] SIZE_BYTE_LO = 2'h0;
   localparam logic [1:0] SIZE_BYTE_HI = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [1:0] SIZE_DWORD = 2'h3;
   // ----------------------------------------
   // segment indices
   // ----------------------------------------
   localparam logic [2:0] SEG_EXTRA = 3'h0;
   localparam logic [2:0] SEG_CODE = 3'h1;
   localparam logic [2:0] SEG_STACK = 3'h2;
   localparam logic [2:0] SEG_DATA = 3'h3;
   localparam logic [2:0] SEG_ADD_F = 3'h4;
   localparam logic [2:0] SEG_ADD_G = 3'h5;
   // ----------------------------------------
   // addressing field codes
   // ----------------------------------------
   localparam logic [2:0] INDEX_NONE = 3'h4;
   localparam logic [2:0] LOCATOR_SIB = 3'h4;
   localparam logic [1:0] MODE_NO_DISP = 2'h0;
   localparam logic [1:0] MODE_DISP_BYTE = 2'h1;
   localparam logic [1:0] MODE_DISP_DWORD = 2'h2;
   localparam logic [1:0] MODE_REGISTER = 2'h3;
   localparam logic [2:0] BASE_STACK = 3'h4;
   localparam logic [2:0] BASE_FRAME = 3'h5;
   // displacement kind on disp_kind_out
   localparam logic [1:0] DISP_NONE = 2'h0;
   localparam logic [1:0] DISP_BYTE = 2'h1;
   localparam logic [1:0] DISP_DWORD = 2'h2;
   // ----------------------------------------
   // identification instruction
   // ----------------------------------------
   localparam logic [15:0] IDENT_OPCODE = 16'h0FA2;
   localparam logic [31:0] IDENT_LEAF_VENDOR = 32'h0000_0000;
   // vendor words: arbitrary neutral values spelling "NeutalCorre0"
   localparam logic [31:0] VENDOR_WORD_B = 32'h7475_654E;
   localparam logic [31:0] VENDOR_WORD_D = 32'h6F43_6C61;
   localparam logic [31:0] VENDOR_WORD_C = 32'h3065_7272;
endpackage

// ---- src/oafd_decoder.sv ----
// operand and address field decoder with gated identification instruction
`timescale 1ns/1ps
`default_nettype none
module oafd_decoder (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   // decode request from front end
   input wire logic decode_valid_in,
   input wire logic [2:0] reg_field_in,
   input wire logic width_present_in,
   input wire logic width_bit_in,
   input wire logic op32_in,
   input wire logic [2:0] segment_select_wide_in,
   input wire logic [1:0] segment_select_narrow_in,
   input wire logic [1:0] mode_field_in,
   input wire logic [2:0] locator_field_in,
   input wire logic addr32_in,
   input wire logic [1:0] scale_field_in,
   input wire logic [2:0] index_field_in,
   input wire logic [2:0] base_field_in,
   input wire logic [31:0] index_value_in,
   input wire logic [31:0] base_value_in,
   input wire logic [7:0] disp_byte_in,
   input wire logic [31:0] disp_dword_in,
   // identification control
   input wire logic [15:0] opcode_in,
   input wire logic config_control_four_ident_en_in,
   input wire logic [31:0] accumulator_dword_in,
   // register operand answer
   output logic decode_valid_out,
   output logic [2:0] reg_sel_out,
   output logic [1:0] reg_size_out,
   // segment answers
   output logic [2:0] seg_wide_out,
   output logic seg_wide_valid_out,
   output logic [2:0] seg_narrow_out,
   // address form answer
   output logic sib_present_out,
   output logic [3:0] scale_mult_out,
   output logic index_used_out,
   output logic [2:0] index_sel_out,
   output logic base_used_out,
   output logic [2:0] base_sel_out,
   output logic [2:0] addr_seg_out,
   output logic [1:0] disp_kind_out,
   output logic [31:0] eff_offset_out,
   // identification answer
   output logic ident_exec_out,
   output logic ident_undefined_out,
   output logic vendor_write_out,
   output logic [31:0] base_gpr_dword_out,
   output logic [31:0] data_gpr_dword_out,
   output logic [31:0] counter_dword_out
);
   // ----------------------------------------
   // combinational decode
   // ----------------------------------------
   logic [1:0] next_reg_size;
   logic [2:0] next_reg_sel;
   logic next_sib;
   logic [3:0] next_scale;
   logic next_index_used;
   logic next_base_used;
   logic [2:0] next_base_sel;
   logic [2:0] next_addr_seg;
   logic [1:0] next_disp_kind;
   logic [31:0] next_disp;
   logic [31:0] next_scaled;
   logic [31:0] next_offset;
   logic next_ident_hit;
   logic next_vendor_hit;

   always_comb begin
      next_reg_sel = reg_field_in;
      if (!width_present_in || width_bit_in) begin
         next_reg_size = op32_in ? oafd_pkg::SIZE_DWORD : oafd_pkg::SIZE_WORD;
      end else if (reg_field_in[2]) begin
         // high byte lives in registers 0-3
         next_reg_size = oafd_pkg::SIZE_BYTE_HI;
         next_reg_sel = {1'b0, reg_field_in[1:0]};
      end else begin
         next_reg_size = oafd_pkg::SIZE_BYTE_LO;
      end
   end

   always_comb begin
      next_sib = addr32_in && (locator_field_in == oafd_pkg::LOCATOR_SIB)
         && (mode_field_in != oafd_pkg::MODE_REGISTER);
      // power of two; code 10 taken as four
      unique case (scale_field_in)
         2'h0: next_scale = 4'h1;
         2'h1: next_scale = 4'h2;
         2'h2: next_scale = 4'h4;
         2'h3: next_scale = 4'h8;
      endcase
      // scale adds nothing with no index (scaled term is zero); the source keeps scale 00 then
      next_index_used = next_sib && (index_field_in != oafd_pkg::INDEX_NONE);
      next_base_sel = next_sib ? base_field_in : locator_field_in;
      next_base_used = 1'b1;
      next_addr_seg = oafd_pkg::SEG_DATA;
      unique case (mode_field_in)
         oafd_pkg::MODE_DISP_BYTE: next_disp_kind = oafd_pkg::DISP_BYTE;
         oafd_pkg::MODE_DISP_DWORD: next_disp_kind = oafd_pkg::DISP_DWORD;
         default: next_disp_kind = oafd_pkg::DISP_NONE;
      endcase
      if (next_base_sel == oafd_pkg::BASE_STACK && next_sib) begin
         next_addr_seg = oafd_pkg::SEG_STACK;
      end else if (next_base_sel == oafd_pkg::BASE_FRAME) begin
         if (mode_field_in == oafd_pkg::MODE_NO_DISP) begin
            next_base_used = 1'b0;
            next_disp_kind = oafd_pkg::DISP_DWORD;
         end else begin
            next_addr_seg = oafd_pkg::SEG_STACK;
         end
      end
      unique case (next_disp_kind)
         oafd_pkg::DISP_BYTE: next_disp = {{24{disp_byte_in[7]}}, disp_byte_in};
         oafd_pkg::DISP_DWORD: next_disp = disp_dword_in;
         default: next_disp = 32'h0000_0000;
      endcase
      next_scaled = next_index_used ? index_value_in * {28'h0000000, next_scale} : 32'h0;
      next_offset = (next_base_used ? base_value_in : 32'h0) + next_scaled + next_disp;
      next_ident_hit = decode_valid_in && (opcode_in == oafd_pkg::IDENT_OPCODE);
      // only leaf zero returns the vendor string; other leaves just execute
      next_vendor_hit = next_ident_hit && config_control_four_ident_en_in
         && (accumulator_dword_in == oafd_pkg::IDENT_LEAF_VENDOR);
   end

   // ----------------------------------------
   // registered operand answers
   // ----------------------------------------
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         decode_valid_out <= 1'b0;
      end else begin
         decode_valid_out <= decode_valid_in;
      end
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         reg_sel_out <= 3'h0;
         reg_size_out <= 2'h0;
      end else begin
         reg_sel_out <= next_reg_sel;
         reg_size_out <= next_reg_size;
      end
   end

   // ----------------------------------------
   // registered segment answers
   // ----------------------------------------
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         seg_wide_out <= 3'h0;
         seg_wide_valid_out <= 1'b0;
      end else begin
         // field codes line up with segment indices 0..5
         seg_wide_out <= segment_select_wide_in;
         seg_wide_valid_out <= (segment_select_wide_in <= oafd_pkg::SEG_ADD_G);
      end
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         seg_narrow_out <= 3'h0;
      end else begin
         seg_narrow_out <= {1'b0, segment_select_narrow_in};
      end
   end

   // ----------------------------------------
   // registered address form answers
   // ----------------------------------------
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sib_present_out <= 1'b0;
      end else begin
         sib_present_out <= next_sib;
      end
   end

   // reset value is the neutral multiplier so downstream never sees zero
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         scale_mult_out <= 4'h1;
      end else begin
         scale_mult_out <= next_scale;
      end
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         index_used_out <= 1'b0;
         index_sel_out <= 3'h0;
      end else begin
         index_used_out <= next_index_used;
         index_sel_out <= index_field_in;
      end
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         base_used_out <= 1'b0;
         base_sel_out <= 3'h0;
      end else begin
         base_used_out <= next_base_used;
         base_sel_out <= next_base_sel;
      end
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         addr_seg_out <= 3'h0;
      end else begin
         addr_seg_out <= next_addr_seg;
      end
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         disp_kind_out <= 2'h0;
      end else begin
         disp_kind_out <= next_disp_kind;
      end
   end

   // ----------------------------------------
   // registered effective offset
   // ----------------------------------------
   // sum wraps modulo 2^32, as the address adder does
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         eff_offset_out <= 32'h0;
      end else begin
         eff_offset_out <= next_offset;
      end
   end

   // ----------------------------------------
   // identification instruction
   // ----------------------------------------
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ident_exec_out <= 1'b0;
      end else begin
         ident_exec_out <= next_ident_hit && config_control_four_ident_en_in;
      end
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ident_undefined_out <= 1'b0;
      end else begin
         ident_undefined_out <= next_ident_hit && !config_control_four_ident_en_in;
      end
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         vendor_write_out <= 1'b0;
      end else begin
         vendor_write_out <= next_vendor_hit;
      end
   end

   // words hold their last value so a later reader still sees the string
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         base_gpr_dword_out <= 32'h0;
         data_gpr_dword_out <= 32'h0;
         counter_dword_out <= 32'h0;
      end else begin
         if (next_vendor_hit) begin
            base_gpr_dword_out <= oafd_pkg::VENDOR_WORD_B;
            data_gpr_dword_out <= oafd_pkg::VENDOR_WORD_D;
            counter_dword_out <= oafd_pkg::VENDOR_WORD_C;
         end
      end
   end
endmodule
`default_nettype wire

// ---- verif/oafd_decoder_properties.sv ----
// assertion checker for the operand and address field decoder
`timescale 1ns/1ps
`default_nettype none
module oafd_decoder_properties (
   // request side
   input wire logic ref_clk_in, resetn_in, decode_valid_in, config_control_four_ident_en_in,
   input wire logic width_present_in, width_bit_in,
   input wire logic [15:0] opcode_in,
   input wire logic [31:0] accumulator_dword_in,
   input wire logic [2:0] reg_field_in, segment_select_wide_in,
   input wire logic [1:0] segment_select_narrow_in, scale_field_in,
   // answer side
   input wire logic ident_exec_out, ident_undefined_out, vendor_write_out,
   input wire logic seg_wide_valid_out,
   input wire logic [2:0] reg_sel_out, seg_wide_out, seg_narrow_out,
   input wire logic [1:0] reg_size_out,
   input wire logic [3:0] scale_mult_out,
   input wire logic [31:0] base_gpr_dword_out, data_gpr_dword_out, counter_dword_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);
   logic hit;
   logic en;
   assign hit = decode_valid_in && opcode_in == oafd_pkg::IDENT_OPCODE;
   assign en = config_control_four_ident_en_in;
   chk_ident_runs: assert property (hit && en |=> ident_exec_out && !ident_undefined_out)
      else $error("identification did not run");
   chk_ident_refused: assert property (hit && !en |=> ident_undefined_out && !vendor_write_out)
      else $error("identification not refused");
   chk_vendor_load: assert property (hit && en && accumulator_dword_in == 32'h0 |=>
      base_gpr_dword_out == oafd_pkg::VENDOR_WORD_B && data_gpr_dword_out == oafd_pkg::VENDOR_WORD_D
      && counter_dword_out == oafd_pkg::VENDOR_WORD_C) else $error("vendor words wrong");
   chk_vendor_hold: assert property (!vendor_write_out |-> $stable(base_gpr_dword_out)
      && $stable(counter_dword_out)) else $error("vendor words moved");
   chk_scale_mult: assert property (1'b1 |=> scale_mult_out == 4'h1 << $past(scale_field_in))
      else $error("scale multiplier wrong");
   chk_wide_seg: assert property (1'b1 |=> seg_wide_valid_out == ($past(segment_select_wide_in) < 3'h6))
      else $error("wide segment validity wrong");
   chk_narrow_seg: assert property (1'b1 |=> seg_narrow_out == {1'b0, $past(segment_select_narrow_in)})
      else $error("narrow segment wrong");
   chk_byte_reg: assert property (width_present_in && !width_bit_in |=> reg_size_out[1] == 1'b0
      && reg_size_out[0] == $past(reg_field_in[2])) else $error("byte register wrong");
   cover property (hit && en && accumulator_dword_in == 32'h0);
   cover property (hit && !en);
   cover property (!seg_wide_valid_out);
endmodule
bind oafd_decoder oafd_decoder_properties chk (.*);
`default_nettype wire

// ---- verif/oafd_front_end_model.sv ----
// front end model issuing one decode request per cycle
`timescale 1ns/1ps
`default_nettype none
module oafd_front_end_model (
   // random material
   input wire logic [181:0] rnd_in,
   // packed request fields
   output logic [178:0] instr_out
);
   assign instr_out[178:50] = rnd_in[178:50];
   assign instr_out[49:48] = (rnd_in[52:50] == 3'h4) ? 2'h0 : rnd_in[49:48];
   // half the requests carry the identification opcode, half a zero leaf
   assign instr_out[47:32] = rnd_in[180] ? oafd_pkg::IDENT_OPCODE : rnd_in[47:32];
   assign instr_out[31:0] = rnd_in[181] ? 32'h0 : rnd_in[31:0];
endmodule
`default_nettype wire

// ---- verif/oafd_decoder_tb_top.sv ----
// self-checking testbench for the operand and address field decoder
`timescale 1ns/1ps
`default_nettype none
module oafd_decoder_tb_top;
   logic ref_clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic decode_valid_in, width_present_in, width_bit_in, op32_in, addr32_in;
   logic config_control_four_ident_en_in, seg_wide_valid_out, sib_present_out;
   logic [2:0] reg_field_in, segment_select_wide_in, locator_field_in, index_field_in, base_field_in;
   logic [1:0] segment_select_narrow_in, mode_field_in, scale_field_in, reg_size_out, disp_kind_out;
   logic [31:0] index_value_in, base_value_in, disp_dword_in, accumulator_dword_in, eff_offset_out;
   logic [7:0] disp_byte_in;
   logic [15:0] opcode_in;
   logic decode_valid_out, index_used_out, base_used_out;
   logic ident_exec_out, ident_undefined_out, vendor_write_out;
   logic [2:0] reg_sel_out, seg_wide_out, seg_narrow_out, index_sel_out, base_sel_out, addr_seg_out;
   logic [3:0] scale_mult_out;
   logic [31:0] base_gpr_dword_out, data_gpr_dword_out, counter_dword_out;
   logic [191:0] rnd = '0;
   logic [178:0] instr;
   logic [31:0] lfsr_state = 32'hD440;
   logic [99:0] exp_reg, exp_seg, exp_addr, exp_id, mask;
   logic [95:0] words = '0;
   int errors = 0;
   int total_checks = 0;
   assign {decode_valid_in, reg_field_in, width_present_in, width_bit_in, op32_in,
      segment_select_wide_in, segment_select_narrow_in, mode_field_in, locator_field_in, addr32_in,
      base_field_in, index_value_in, base_value_in, disp_byte_in, disp_dword_in,
      config_control_four_ident_en_in, index_field_in, scale_field_in, opcode_in,
      accumulator_dword_in} = instr;
   oafd_decoder dut (.*);
   oafd_front_end_model front (.rnd_in(rnd[181:0]), .instr_out(instr));
   always #25 ref_clk_in = ~ref_clk_in;
   // ----------------------------------------
   // reference model and comparison
   // ----------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [99:0] got, input logic [99:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic predict();
      logic lo, sib, nb, iu, hit;
      logic [2:0] b;
      logic [1:0] dk;
      logic [31:0] d;
      lo = width_present_in && !width_bit_in;
      exp_reg = {lo ? {1'b0, reg_field_in[1:0]} : reg_field_in, lo ? {1'b0, reg_field_in[2]}
         : {1'b1, op32_in}};
      exp_seg = {segment_select_wide_in, segment_select_wide_in < 3'h6, 1'b0, segment_select_narrow_in};
      sib = addr32_in && locator_field_in == 3'h4 && mode_field_in != 2'h3;
      b = sib ? base_field_in : locator_field_in;
      nb = mode_field_in == 2'h0 && b == 3'h5;
      dk = nb ? 2'h2 : mode_field_in;
      iu = sib && index_field_in != 3'h4;
      d = dk == 2'h1 ? {{24{disp_byte_in[7]}}, disp_byte_in} : dk == 2'h2 ? disp_dword_in : 32'h0;
      exp_addr = {sib, 4'h1 << scale_field_in, iu, index_field_in, !nb, b,
         ((sib && b == 3'h4) || (b == 3'h5 && !nb)) ? 3'h2 : 3'h3, dk,
         (nb ? 32'h0 : base_value_in) + (iu ? index_value_in << scale_field_in : 32'h0) + d};
      mask = mode_field_in == 2'h3 ? 100'h2000000000000 : '1;
      hit = decode_valid_in && opcode_in == 16'h0FA2;
      if (hit && config_control_four_ident_en_in && accumulator_dword_in == 32'h0) begin
         words = {oafd_pkg::VENDOR_WORD_B, oafd_pkg::VENDOR_WORD_D, oafd_pkg::VENDOR_WORD_C};
      end
      exp_id = {decode_valid_in, hit && config_control_four_ident_en_in,
         hit && !config_control_four_ident_en_in,
         hit && config_control_four_ident_en_in && accumulator_dword_in == 32'h0, words};
   endtask
   task automatic conclude();
      $display("errors %0d checks %0d", errors, total_checks);
      if (errors == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (2) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      check({scale_mult_out, eff_offset_out, base_gpr_dword_out}, {4'h1, 64'h0});
      resetn_in = 1'b1;
      predict();
      repeat (3000) begin
         @(negedge ref_clk_in);
         check({reg_sel_out, reg_size_out}, exp_reg);
         check({seg_wide_out, seg_wide_valid_out, seg_narrow_out}, exp_seg);
         check(mask & {sib_present_out, scale_mult_out, index_used_out, index_sel_out, base_used_out,
            base_sel_out, addr_seg_out, disp_kind_out, eff_offset_out}, mask & exp_addr);
         check({decode_valid_out, ident_exec_out, ident_undefined_out, vendor_write_out,
            base_gpr_dword_out, data_gpr_dword_out, counter_dword_out}, exp_id);
         repeat (6) begin
            repeat (32) lfsr_state = lfsr(lfsr_state);
            rnd = {rnd[159:0], lfsr_state};
         end
         #1;
         predict();
      end
      conclude();
   end
   initial begin
      #(4000 * 50);
      errors++;
      conclude();
   end
endmodule
`default_nettype wire
